// >>> common/cps_consts.svh
// constants for the program sequencer: widths, vectors, status layout, opcode groups
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

`define CPS_AW 12
`define CPS_DW 8
`define CPS_NGPR 8
`define CPS_RSEL_W 3
`define CPS_STK_DEPTH 7
`define CPS_SP_W 3

`define CPS_PC_RESET 12'h000
`define CPS_INT_VEC 12'h002
`define CPS_RESET_MIN_CYC 3

`define CPS_SW_C 7
`define CPS_SW_D 6
`define CPS_SW_I 5
`define CPS_SW_A 4
`define CPS_SW_H 3

`define CPS_BCD_LIMIT 5'h09
`define CPS_BCD_ADJ 5'h06

`define CPS_GRP_MISC 4'h0
`define CPS_GRP_INCDEC 4'h1
`define CPS_GRP_JIN_INP 4'h2
`define CPS_GRP_OUT_STA 4'h3
`define CPS_GRP_ARITH 4'h4
`define CPS_GRP_CMP_AND 4'h5
`define CPS_GRP_LDA 4'h6
`define CPS_GRP_JMP 4'h8
`define CPS_GRP_JSR 4'h9
`define CPS_GRP_JCOND 4'hA
`define CPS_GRP_LDI 4'hB

`define CPS_MISC_RET 4'h1
`define CPS_MISC_SETD 4'h2
`define CPS_MISC_CLRD 4'h3
`define CPS_MISC_EI 4'h4
`define CPS_MISC_DI 4'h5
`define CPS_MISC_RDST 4'h6

`define CPS_CC_ACC0 2'h0
`define CPS_CC_ACC1 2'h1
`define CPS_CC_C1 2'h2

`endif

// >>> common/cps_pkg.sv
// types shared by the program sequencer modules
`include "cps_consts.svh"
package cps_pkg;
	typedef enum logic [1:0] {S_T1, S_T2, S_T3, S_T4} cps_state_e;
	typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_CMP} cps_aluop_e;
	typedef struct packed {
		logic [`CPS_AW-1:0] addr;
		logic [`CPS_DW-1:0] data;
		logic data_oe;
		logic read_strobe_n;
		logic write_strobe_n;
	} cps_bus_s;
	typedef struct packed {
		logic o;
		logic oe;
	} cps_pin_s;
	typedef struct packed {
		logic c;
		logic d;
		logic i;
		logic h;
	} cps_flags_s;
endpackage

// >>> design/cps_alu.sv
// accumulator arithmetic: direct binary/bcd add and subtract, and, compare
`include "cps_consts.svh"
module cps_alu (
	// operands
	input wire logic [`CPS_DW-1:0] a,
	input wire logic [`CPS_DW-1:0] b,
	input wire cps_pkg::cps_aluop_e op,
	input wire logic decimal,
	// results
	output logic [`CPS_DW-1:0] res,
	output logic carry,
	output logic half
);
	import cps_pkg::*;

	// addition, digit-wise adjust in decimal mode
	wire [4:0] alo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
	wire alo_adj = decimal && (alo > `CPS_BCD_LIMIT);
	wire [4:0] alo_fix = alo_adj ? alo + `CPS_BCD_ADJ : alo;
	wire ahc = alo[4] | alo_adj;
	wire [4:0] ahi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, ahc};
	wire ahi_adj = decimal && (ahi > `CPS_BCD_LIMIT);
	wire [4:0] ahi_fix = ahi_adj ? ahi + `CPS_BCD_ADJ : ahi;
	wire acy = ahi[4] | ahi_adj;

	// direct subtraction, borrow out means negative
	wire [4:0] slo = {1'b0, a[3:0]} - {1'b0, b[3:0]};
	wire [4:0] slo_fix = (decimal && slo[4]) ? slo - `CPS_BCD_ADJ : slo;
	wire [4:0] shi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, slo[4]};
	wire [4:0] shi_fix = (decimal && shi[4]) ? shi - `CPS_BCD_ADJ : shi;

	wire is_add = (op == ALU_ADD);
	wire is_and = (op == ALU_AND);

	assign res = is_add ? {ahi_fix[3:0], alo_fix[3:0]} : is_and ? (a & b) : {shi_fix[3:0], slo_fix[3:0]};
	assign carry = is_add ? acy : (!is_and && shi[4]);
	assign half = is_add ? ahc : (!is_and && slo[4]);
endmodule // cps_alu

// >>> design/cps_stack.sv
// seven-entry cascade return stack with level counter
`include "cps_consts.svh"
module cps_stack #(
	parameter int DEPTH = `CPS_STK_DEPTH,
	parameter int AW = `CPS_AW,
	parameter int SPW = `CPS_SP_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// control
	input wire logic clear,
	input wire logic push,
	input wire logic pop,
	input wire logic [AW-1:0] push_val,
	// state
	output logic [AW-1:0] top,
	output logic [SPW-1:0] level
);
	import cps_pkg::*;

	logic [AW-1:0] ent_r [DEPTH];
	logic [AW-1:0] from_up [DEPTH];
	logic [AW-1:0] from_dn [DEPTH];
	logic [SPW-1:0] level_r;

	genvar gi;
	for (gi = 0; gi < DEPTH; gi++) begin : g_ent
		if (gi == 0) begin : g_first
			assign from_up[gi] = push_val;
		end else begin : g_mid
			assign from_up[gi] = ent_r[gi-1];
		end
		if (gi == DEPTH-1) begin : g_last
			assign from_dn[gi] = '0;
		end else begin : g_low
			assign from_dn[gi] = ent_r[gi+1];
		end
		always_ff @(posedge clk_sys or negedge nrst) begin
			if (!nrst)
				ent_r[gi] <= '0;
			else if (clear)
				ent_r[gi] <= '0;
			else if (push)
				ent_r[gi] <= from_up[gi];
			else if (pop)
				ent_r[gi] <= from_dn[gi];
		end
	end

	// an eighth push wraps the level; the oldest entry is lost
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			level_r <= '0;
		else if (clear)
			level_r <= '0;
		else if (push)
			level_r <= level_r + 1'b1;
		else if (pop && level_r != '0)
			level_r <= level_r - 1'b1;
	end

	assign top = ent_r[0];
	assign level = level_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	stack_push_a: assert property (push && !clear |=> top == $past(push_val) && level == $past(level) + 1'b1)
		else $error("push did not store value on top");
	stack_pop_a: assert property (pop && !push && !clear && level != '0 |=> level == $past(level) - 1'b1)
		else $error("pop did not lower the level");
endmodule // cps_stack

// >>> design/cps_sequencer.sv
// program sequencer core: fetch, jumps, calls, flags, interrupt and control bus
// Summary of operation
// - general register increment and decrement act on all twelve bits.
// - twelve-bit program counter steps past each fetched byte unless a jump loads it.
// - instruction bytes are fetched only over the external bus.
// - direct jump loads the twelve-bit target carried in the instruction.
// - indirect jump loads the twelve-bit value of the selected register.
// - taken conditional jump replaces low eight counter bits, keeps the page.
// - seven-entry internal stack; a call pushes the counter before loading the target.
// - three-bit stack level is kept and readable in the status word.
// - return pops the newest entry into the counter, level drops by one.
// - nesting depth is seven; an eighth push overflows and corrupts returns.
// - interrupt enabled and request low is taken at instruction end, with exceptions.
// - acknowledge forces a call to 002 and clears interrupt enable.
// - carry is carry out of bit 7; negative subtraction sets it.
// - half carry is carry out of bit 3.
// - accumulator flag shows nonzero, or a compare outcome for one instruction.
// - decimal mode adds and subtracts packed bcd, sums correct to 199.
// - status word packs carry, decimal, enable, accumulator, half carry, level.
// - clear held low at least three clocks empties stack and clears counter, D, I.
// - wait/sync is driven low in the last clock of every instruction.
// - wait/sync held low from outside stops the core before the next fetch.
// - write strobe goes low only while address and data are stable.
// - read strobe goes low with a valid address on the bus.
`include "cps_consts.svh"
module cps_sequencer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// control bus pins
	input wire logic chip_clear_n,
	input wire logic irq_n,
	input wire logic wait_sync_i,
	output cps_pkg::cps_pin_s wait_sync,
	// address and data bus
	input wire logic [`CPS_DW-1:0] data_i,
	output cps_pkg::cps_bus_s bus,
	// visible state
	output logic [`CPS_DW-1:0] status_word,
	output logic [`CPS_DW-1:0] acc
);
	import cps_pkg::*;

	cps_state_e st_r, st_nxt;
	logic mc_r, mc_nxt;
	logic [`CPS_AW-1:0] pc_r, pc_nxt, pc_go, push_pc;
	logic [`CPS_DW-1:0] ir_r, opr_r, acc_r;
	logic [`CPS_AW-1:0] gpr_r [`CPS_NGPR];
	cps_flags_s fl_r;
	logic cmp_show_r, cmp_res_r;
	logic [`CPS_AW-1:0] stk_top;
	logic [`CPS_SP_W-1:0] stk_level;
	logic [`CPS_DW-1:0] alu_res;
	logic alu_c, alu_h;
	cps_aluop_e alu_op;

	// instruction decode
	wire [3:0] grp = ir_r[7:4];
	wire sub = ir_r[3];
	wire [`CPS_RSEL_W-1:0] rs = ir_r[2:0];
	wire [`CPS_AW-1:0] reg_sel = gpr_r[rs];
	wire is_misc = (grp == `CPS_GRP_MISC);
	wire is_ret = is_misc && (ir_r[3:0] == `CPS_MISC_RET);
	wire is_setd = is_misc && (ir_r[3:0] == `CPS_MISC_SETD);
	wire is_clrd = is_misc && (ir_r[3:0] == `CPS_MISC_CLRD);
	wire is_ei = is_misc && (ir_r[3:0] == `CPS_MISC_EI);
	wire is_di = is_misc && (ir_r[3:0] == `CPS_MISC_DI);
	wire is_rdst = is_misc && (ir_r[3:0] == `CPS_MISC_RDST);
	wire is_inc = (grp == `CPS_GRP_INCDEC) && !sub;
	wire is_dec = (grp == `CPS_GRP_INCDEC) && sub;
	wire is_jin = (grp == `CPS_GRP_JIN_INP) && !sub;
	wire is_inp = (grp == `CPS_GRP_JIN_INP) && sub;
	wire is_out = (grp == `CPS_GRP_OUT_STA) && !sub;
	wire is_sta = (grp == `CPS_GRP_OUT_STA) && sub;
	wire is_arith = (grp == `CPS_GRP_ARITH);
	wire is_cmp = (grp == `CPS_GRP_CMP_AND) && !sub;
	wire is_and = (grp == `CPS_GRP_CMP_AND) && sub;
	wire is_lda = (grp == `CPS_GRP_LDA);
	wire is_jmp = (grp == `CPS_GRP_JMP);
	wire is_jsr = (grp == `CPS_GRP_JSR);
	wire is_jcond = (grp == `CPS_GRP_JCOND);
	wire is_ldi = (grp == `CPS_GRP_LDI);
	wire is_alu = is_arith || is_cmp || is_and;
	wire two_byte = is_jmp || is_jsr || is_jcond || is_ldi;
	wire need_m2 = two_byte || (fl_r.d && is_arith);

	// cycle position
	wire in_t12 = (st_r == S_T1) || (st_r == S_T2);
	wire in_t34 = (st_r == S_T3) || (st_r == S_T4);
	wire stall = (st_r == S_T1) && !wait_sync_i;
	wire fetching = in_t12 && !stall && (!mc_r || two_byte);
	wire last_t4 = (st_r == S_T4) && (mc_r || !need_m2);
	wire exec = last_t4;
	wire io_phase = in_t34 && !mc_r;

	// accumulator flag and conditions
	wire acc_flag = cmp_show_r ? cmp_res_r : (acc_r != '0);
	wire cond_ok = (ir_r[1:0] == `CPS_CC_ACC0) ? !acc_flag :
		(ir_r[1:0] == `CPS_CC_ACC1) ? acc_flag :
		(ir_r[1:0] == `CPS_CC_C1) ? fl_r.c : !fl_r.c;

	// calls and returns are not interrupted at their own end
	wire int_block = is_jsr || is_ret || is_ei;
	wire take_int = exec && fl_r.i && !irq_n && !int_block;
	wire stk_push = (exec && is_jsr) || take_int;
	wire stk_pop = exec && is_ret && !take_int;
	wire clr = !chip_clear_n;

	assign alu_op = is_cmp ? ALU_CMP : is_and ? ALU_AND : sub ? ALU_SUB : ALU_ADD;

	cps_alu u_alu (
		.a(acc_r),
		.b(reg_sel[`CPS_DW-1:0]),
		.op(alu_op),
		.decimal(fl_r.d),
		.res(alu_res),
		.carry(alu_c),
		.half(alu_h)
	);

	cps_stack u_stack (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.clear(clr),
		.push(stk_push),
		.pop(stk_pop),
		.push_val(push_pc),
		.top(stk_top),
		.level(stk_level)
	);

	// program counter next value
	always_comb begin
		pc_go = pc_r;
		if (fetching && st_r == S_T2)
			pc_go = pc_r + 12'h001;
		if (exec) begin
			if (is_jin)
				pc_go = reg_sel;
			else if (is_jmp || is_jsr)
				pc_go = {ir_r[3:0], opr_r};
			else if (is_jcond && cond_ok)
				pc_go = {pc_r[`CPS_AW-1:8], opr_r};
			else if (is_ret)
				pc_go = stk_top;
		end
	end
	// an interrupt returns to where the finished instruction was heading
	assign pc_nxt = take_int ? `CPS_INT_VEC : pc_go;
	assign push_pc = take_int ? pc_go : pc_r;

	// state sequence T1..T4, second machine cycle when needed
	always_comb begin
		st_nxt = st_r;
		mc_nxt = mc_r;
		case (st_r)
			S_T1: begin
				if (!stall)
					st_nxt = S_T2;
			end
			S_T2: st_nxt = S_T3;
			S_T3: st_nxt = S_T4;
			S_T4: begin
				st_nxt = S_T1;
				mc_nxt = !last_t4;
			end
			default: st_nxt = S_T1;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= S_T1;
			mc_r <= 1'b0;
			pc_r <= `CPS_PC_RESET;
		end else if (clr) begin
			st_r <= S_T1;
			mc_r <= 1'b0;
			pc_r <= `CPS_PC_RESET;
		end else begin
			st_r <= st_nxt;
			mc_r <= mc_nxt;
			pc_r <= pc_nxt;
		end
	end

	// fetched bytes, sampled in T2 while read strobe is low
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ir_r <= '0;
			opr_r <= '0;
		end else if (fetching && st_r == S_T2) begin
			if (!mc_r)
				ir_r <= data_i;
			else
				opr_r <= data_i;
		end
	end

	// general registers, twelve bits wide
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < `CPS_NGPR; i++)
				gpr_r[i] <= '0;
		end else if (exec && !clr) begin
			if (is_inc)
				gpr_r[rs] <= reg_sel + 12'h001;
			else if (is_dec)
				gpr_r[rs] <= reg_sel - 12'h001;
			else if (is_sta)
				gpr_r[rs][`CPS_DW-1:0] <= acc_r;
		end
	end

	// accumulator
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			acc_r <= '0;
		else if (clr)
			acc_r <= '0;
		else if (is_inp && io_phase && st_r == S_T4)
			acc_r <= data_i;
		else if (exec && (is_arith || is_and))
			acc_r <= alu_res;
		else if (exec && is_lda)
			acc_r <= reg_sel[`CPS_DW-1:0];
		else if (exec && is_ldi)
			acc_r <= opr_r;
		else if (exec && is_rdst)
			acc_r <= status_word;
	end

	// status flags
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fl_r <= '0;
			cmp_show_r <= 1'b0;
			cmp_res_r <= 1'b0;
		end else if (clr) begin
			fl_r <= '0;
			cmp_show_r <= 1'b0;
			cmp_res_r <= 1'b0;
		end else if (exec) begin
			if (is_alu) begin
				fl_r.c <= alu_c;
				fl_r.h <= alu_h;
			end
			if (is_setd)
				fl_r.d <= 1'b1;
			else if (is_clrd)
				fl_r.d <= 1'b0;
			if (take_int)
				fl_r.i <= 1'b0;
			else if (is_ei)
				fl_r.i <= 1'b1;
			else if (is_di)
				fl_r.i <= 1'b0;
			cmp_show_r <= is_cmp;
			if (is_cmp)
				cmp_res_r <= (alu_res != '0);
		end
	end

	// status word layout
	always_comb begin
		status_word = '0;
		status_word[`CPS_SW_C] = fl_r.c;
		status_word[`CPS_SW_D] = fl_r.d;
		status_word[`CPS_SW_I] = fl_r.i;
		status_word[`CPS_SW_A] = acc_flag;
		status_word[`CPS_SW_H] = fl_r.h;
		status_word[`CPS_SP_W-1:0] = stk_level;
	end
	assign acc = acc_r;

	// external bus
	assign bus.addr = (io_phase && (is_inp || is_out)) ? reg_sel : pc_r;
	assign bus.data = acc_r;
	assign bus.data_oe = io_phase && is_out;
	assign bus.read_strobe_n = !(fetching || (io_phase && is_inp));
	assign bus.write_strobe_n = !(io_phase && is_out && st_r == S_T4);
	assign wait_sync.o = 1'b0;
	assign wait_sync.oe = last_t4;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	pc_advance_a: assert property (st_r == S_T2 && fetching && chip_clear_n |=> pc_r == $past(pc_r) + 12'h001)
		else $error("program counter did not step after fetch");
	fetch_addr_a: assert property (fetching |-> bus.addr == pc_r && !bus.read_strobe_n)
		else $error("fetch not from program counter");
	page_keep_a: assert property (exec && is_jcond && cond_ok && !take_int && chip_clear_n
		|=> pc_r == {$past(pc_r[`CPS_AW-1:8]), $past(opr_r)})
		else $error("conditional jump left page");
	int_vector_a: assert property (take_int && chip_clear_n |=> pc_r == `CPS_INT_VEC && !fl_r.i
		&& stk_top == $past(pc_go))
		else $error("interrupt entry wrong");
	chip_clear_a: assert property (!chip_clear_n |=> pc_r == `CPS_PC_RESET && stk_level == '0
		&& !fl_r.d && !fl_r.i)
		else $error("clear did not initialise core");
	sync_end_a: assert property (wait_sync.oe |-> st_r == S_T4 ##1 (st_r == S_T1 && !mc_r) || !chip_clear_n)
		else $error("sync not at instruction end");
	wait_hold_a: assert property (st_r == S_T1 && !wait_sync_i && chip_clear_n
		|-> bus.read_strobe_n && bus.write_strobe_n ##1 st_r == S_T1)
		else $error("core ran while wait held");
	write_stable_a: assert property (!bus.write_strobe_n |-> bus.data_oe && $stable(bus.addr)
		&& $stable(bus.data))
		else $error("write strobe with unstable bus");
	acc_flag_a: assert property (!cmp_show_r |-> status_word[`CPS_SW_A] == (acc_r != '0))
		else $error("accumulator flag wrong");
	sub_carry_a: assert property (exec && is_arith && sub && !fl_r.d && chip_clear_n
		|=> fl_r.c == ($past(acc_r) < $past(reg_sel[`CPS_DW-1:0])))
		else $error("subtract carry wrong");
endmodule // cps_sequencer

// >>> testbench/cps_mem_model.sv
// external memory model answering the sequencer's read and write strobes
module cps_mem_model (
	// clock
	input wire logic clk_sys,
	// bus from the sequencer
	input wire cps_pkg::cps_bus_s bus,
	output logic [7:0] data_i
);
	timeunit 1ns;
	timeprecision 1ns;
	import cps_pkg::*;
	logic [7:0] mem [0:4095];
	logic [7:0] last;
	logic [19:0] wq [$];
	// a released bus shows the inverse of the last byte, never a stale copy
	assign data_i = !bus.read_strobe_n ? mem[bus.addr] : ~last;
	initial begin
		last = 8'h00;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	always @(posedge clk_sys) begin
		if (!bus.read_strobe_n) last <= mem[bus.addr];
		// write strobe used as the write pulse
		if (!bus.write_strobe_n) begin
			mem[bus.addr] <= bus.data;
			wq.push_back({bus.addr, bus.data});
		end
	end
endmodule // cps_mem_model

// >>> testbench/tb.sv
// self-checking bench: runs a short program from the memory model and checks the bus traffic
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cps_pkg::*;
	logic clk_sys, nrst, chip_clear_n, irq_n, ext_wait_n, wait_sync_i, prev_oe;
	cps_pin_s wait_sync;
	cps_bus_s bus;
	logic [7:0] data_i, status_word, acc;
	int fail_count, compares, n;
	logic [7:0] ed [11] = '{8'hFF, 8'h11, 8'h10, 8'h11, 8'h10, 8'h18, 8'hFE, 8'h90, 8'h98, 8'hD0, 8'h5A};
	logic [7:0] em [11] = '{8'hFF, 8'h77, 8'h77, 8'h77, 8'h77, 8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hF7, 8'hFF};
	// wire is pulled up; either side may pull it low
	assign wait_sync_i = !wait_sync.oe && ext_wait_n;
	cps_sequencer u_dut (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.chip_clear_n(chip_clear_n),
		.irq_n(irq_n),
		.wait_sync_i(wait_sync_i),
		.wait_sync(wait_sync),
		.data_i(data_i),
		.bus(bus),
		.status_word(status_word),
		.acc(acc)
	);
	cps_mem_model u_mem (
		.clk_sys(clk_sys),
		.bus(bus),
		.data_i(data_i)
	);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic ld(input logic [11:0] a, input logic [7:0] b []);
		foreach (b[i]) u_mem.mem[a + 12'(i)] = b[i];
	endtask
	task automatic final_report();
		if (fail_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		final_report();
	end
	// pin-level watch running beside the program
	always @(negedge clk_sys) begin
		if (nrst && chip_clear_n && ext_wait_n && prev_oe) chk(bus.read_strobe_n, 1'b0);
		if (wait_sync.oe) chk(wait_sync.o, 1'b0);
		if (!bus.write_strobe_n) chk(bus.data_oe, 1'b1);
		prev_oe = nrst && wait_sync.oe;
	end
	initial begin
		nrst = 1'b0;
		chip_clear_n = 1'b1;
		irq_n = 1'b1;
		ext_wait_n = 1'b1;
		prev_oe = 1'b0;
		#1;
		ld(12'h000, '{8'h81, 8'h00, 8'h06, 8'h30, 8'h01});
		ld(12'h0FF, '{8'h30, 8'hB0, 8'hFF, 8'h38, 8'h10, 8'h30, 8'h91, 8'h40,
			8'h06, 8'h30, 8'h04, 8'h00, 8'hA0, 8'hC0, 8'hA1, 8'h80});
		ld(12'h140, '{8'h06, 8'h30, 8'h01});
		ld(12'h1C0, '{8'hB0, 8'hEE, 8'h30});
		ld(12'h180, '{8'hB0, 8'h01, 8'h39, 8'hB0, 8'h0F, 8'h41, 8'h30, 8'h06, 8'h30, 8'hB0, 8'h03, 8'h39, 8'hB0,
			8'h01, 8'h49, 8'h30, 8'h06, 8'h30, 8'h02, 8'hB0, 8'h99, 8'h39, 8'h41, 8'h30, 8'h06, 8'h30,
			8'h03, 8'hB0, 8'h05, 8'h39, 8'h51, 8'hA0, 8'hA4, 8'hB0, 8'hEE, 8'h30, 8'hB0, 8'h5A, 8'h18, 8'h20});
		cyc(20);
		chk(status_word, 8'h00);
		chk({bus.read_strobe_n, bus.write_strobe_n}, 2'b01);
		nrst = 1'b1;
		#1;
		chk(bus.addr, 12'h000);
		chk(bus.read_strobe_n, 1'b0);
		irq_n = 1'b0;
		for (n = 0; n < 3000 && u_mem.wq.size() < 4; n++) cyc(1);
		irq_n = 1'b1;
		for (n = 0; n < 3000 && u_mem.wq.size() < 11; n++) cyc(1);
		// write log: addresses, results and masked status words
		for (int i = 0; i < 11; i++) begin
			chk(u_mem.wq[i][19:8], i == 10 ? 12'h0FF : 12'h100);
			chk(u_mem.wq[i][7:0] & em[i], ed[i]);
		end
		ext_wait_n = 1'b0;
		cyc(12);
		n = u_mem.wq.size();
		repeat (8) begin
			cyc(1);
			chk({bus.read_strobe_n, bus.write_strobe_n}, 2'b11);
		end
		chk(12'(u_mem.wq.size() - n), 12'h000);
		ext_wait_n = 1'b1;
		cyc(30);
		// after the clear, run a short input/and/load program at 200
		ld(12'h000, '{8'h82, 8'h00});
		ld(12'h200, '{8'hB0, 8'hF0, 8'h3A, 8'hB0, 8'h3C, 8'h32, 8'hB0, 8'h00,
			8'h2A, 8'h5A, 8'h32, 8'h62, 8'h32, 8'h05, 8'h82, 8'h0E});
		chip_clear_n = 1'b0;
		cyc(3);
		chk(bus.addr, 12'h000);
		chk(status_word, 8'h00);
		chip_clear_n = 1'b1;
		n = u_mem.wq.size();
		for (int k = 0; k < 300 && u_mem.wq.size() < n + 3; k++) cyc(1);
		chk(u_mem.wq[n][19:8], 12'h0F0);
		chk(u_mem.wq[n][7:0], 8'h3C);
		chk(u_mem.wq[n + 1][7:0], 8'h30);
		chk(u_mem.wq[n + 2][7:0], 8'hF0);
		chk(acc, 8'hF0);
		chk(status_word, 8'h10);
		final_report();
	end
endmodule // tb
